// *** hw/gpio_port.sv ***
// general purpose port block: first and third 8-bit ports, fifth port
// direction with slave port status, analog and oscillator pin sharing.
// assumes an ahb-lite master on clk_sys and slave port logic on clk_sys.
//
// What this block does
// - direction one: pin input, driver off
// - direction zero: pin driven from latch unless handed to the oscillator
// - eight pins, each own direction, latch
// - pin value reads pins, writes latch
// - latch register reads back latched value
// - pin four also feeds timer clock
// - oscillator pins six, seven read zero
// - analog control selects analog pins
// - reset: analog pins zero, pin four digital
// - overflow set on write while full
// - mode bit selects slave port operation
`timescale 1ns/100ps
module gpio_port (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // first port pins
    input wire logic [7:0] first_port_in,
    output logic [7:0] first_port_out,
    output logic [7:0] first_port_oe,
    // third port pins
    input wire logic [7:0] third_port_in,
    output logic [7:0] third_port_out,
    output logic [7:0] third_port_oe,
    // fifth port and slave port events
    input wire logic slave_in_write,
    input wire logic core_in_read,
    input wire logic core_out_write,
    input wire logic slave_out_read,
    output logic [2:0] fifth_port_dir,
    output logic slave_port_mode_select,
    // shared functions
    output logic timer_zero_clock_input
);

    logic [7:0] first_sync;
    logic [7:0] third_sync;
    logic [7:0] first_latch_reg, first_latch_next;
    logic [7:0] first_dir_reg, first_dir_next;
    logic [7:0] third_latch_reg, third_latch_next;
    logic [7:0] third_dir_reg, third_dir_next;
    logic [2:0] fifth_dir_reg, fifth_dir_next;
    logic mode_reg, mode_next;
    logic ibf_reg, ibf_next;
    logic obf_reg, obf_next;
    logic input_buffer_overflow_reg, input_buffer_overflow_next;
    logic [4:0] analog_sel_reg, analog_sel_next;
    logic osc_sel_reg, osc_sel_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_addr_reg, wr_addr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [7:0] first_out_reg, first_out_next;
    logic [7:0] first_oe_reg, first_oe_next;
    logic [7:0] third_out_reg, third_out_next;
    logic [7:0] third_oe_reg, third_oe_next;
    logic timer_clk_reg, timer_clk_next;
    logic addr_phase, ovf_clear;
    logic [7:0] wbyte;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // pins whose digital path is cut by the analog selection
    function automatic logic [7:0] analog_mask(input logic [4:0] sel);
        analog_mask = {2'b00, sel[4], 1'b0, sel[3:0]};
    endfunction

    // pins handed to the oscillator
    function automatic logic [7:0] osc_mask(input logic osc);
        osc_mask = {osc, osc, 6'b00_0000};
    endfunction

    // ----------------------------------------------------------------
    // pin input synchronisers
    // ----------------------------------------------------------------
    pin_sync #(.WIDTH(16)) u_pin_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_in({third_port_in, first_port_in}),
        .pin_sync_out({third_sync, first_sync})
    );

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign addr_phase = hsel & htrans[1] & hready;
    assign wbyte = hwdata[7:0];
    assign ovf_clear = wr_pend_reg && wr_addr_reg == gpio_port_pkg::OFS_FIFTH_DIR_STATUS
        && !wbyte[gpio_port_pkg::FIFTH_INPUT_BUFFER_OVERFLOW_BIT];

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    // writes land in the data phase after the captured address phase
    always_comb begin
        first_latch_next = first_latch_reg;
        first_dir_next = first_dir_reg;
        third_latch_next = third_latch_reg;
        third_dir_next = third_dir_reg;
        fifth_dir_next = fifth_dir_reg;
        mode_next = mode_reg;
        analog_sel_next = analog_sel_reg;
        osc_sel_next = osc_sel_reg;
        input_buffer_overflow_next = input_buffer_overflow_reg;
        if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                gpio_port_pkg::OFS_FIRST_PIN_VALUE,
                gpio_port_pkg::OFS_FIRST_LATCH: first_latch_next = wbyte;
                gpio_port_pkg::OFS_FIRST_DIR: first_dir_next = wbyte;
                gpio_port_pkg::OFS_THIRD_PIN_VALUE,
                gpio_port_pkg::OFS_THIRD_LATCH: third_latch_next = wbyte;
                gpio_port_pkg::OFS_THIRD_DIR: third_dir_next = wbyte;
                gpio_port_pkg::OFS_FIFTH_DIR_STATUS: begin
                    fifth_dir_next = wbyte[gpio_port_pkg::FIFTH_DIR_W-1:0];
                    mode_next = wbyte[gpio_port_pkg::FIFTH_MODE_BIT];
                    // software may only clear the overflow flag
                    if (!wbyte[gpio_port_pkg::FIFTH_INPUT_BUFFER_OVERFLOW_BIT]) begin
                        input_buffer_overflow_next = 1'b0;
                    end
                end
                gpio_port_pkg::OFS_ANALOG_CTRL_ONE: analog_sel_next = wbyte[gpio_port_pkg::ANALOG_SEL_W-1:0];
                gpio_port_pkg::OFS_OSC_PIN_SELECT: osc_sel_next = wbyte[0];
                default: begin
                end
            endcase
        end
        // a new overflow outranks a clear in the same cycle
        if (slave_in_write && ibf_reg) begin
            input_buffer_overflow_next = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // slave port buffer flags
    // ----------------------------------------------------------------
    // set wins over clear; flags never take bus writes
    always_comb begin
        ibf_next = ibf_reg;
        obf_next = obf_reg;
        if (core_in_read) begin
            ibf_next = 1'b0;
        end
        if (slave_in_write) begin
            ibf_next = 1'b1;
        end
        if (slave_out_read) begin
            obf_next = 1'b0;
        end
        if (core_out_write) begin
            obf_next = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // bus phase tracking and read data
    // ----------------------------------------------------------------
    // read data built from next values so a read right behind a write
    // sees the written value without a wait state
    always_comb begin
        logic [7:0] an_m;
        logic [7:0] os_m;
        an_m = analog_mask(analog_sel_next);
        os_m = osc_mask(osc_sel_next);
        wr_pend_next = addr_phase & hwrite;
        wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
        rdata_next = '0;
        if (addr_phase && !hwrite) begin
            unique case (haddr[7:0])
                gpio_port_pkg::OFS_FIRST_PIN_VALUE: rdata_next[7:0] = first_sync & ~an_m & ~os_m;
                gpio_port_pkg::OFS_FIRST_LATCH: rdata_next[7:0] = first_latch_next & ~os_m;
                gpio_port_pkg::OFS_FIRST_DIR: rdata_next[7:0] = first_dir_next & ~os_m;
                gpio_port_pkg::OFS_THIRD_PIN_VALUE: rdata_next[7:0] = third_sync;
                gpio_port_pkg::OFS_THIRD_LATCH: rdata_next[7:0] = third_latch_next;
                gpio_port_pkg::OFS_THIRD_DIR: rdata_next[7:0] = third_dir_next;
                gpio_port_pkg::OFS_FIFTH_DIR_STATUS: begin
                    rdata_next[7:0] = {ibf_next, obf_next, input_buffer_overflow_next, mode_next, 1'b0, fifth_dir_next};
                end
                gpio_port_pkg::OFS_ANALOG_CTRL_ONE: rdata_next[4:0] = analog_sel_next;
                gpio_port_pkg::OFS_OSC_PIN_SELECT: rdata_next[0] = osc_sel_next;
                default: rdata_next = '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // built from next values so pins follow the write in one edge;
    // oscillator pins are never driven by the port
    always_comb begin
        logic [7:0] os_m;
        os_m = osc_mask(osc_sel_next);
        first_oe_next = ~first_dir_next & ~os_m;
        first_out_next = first_latch_next & ~os_m;
        third_oe_next = ~third_dir_next;
        third_out_next = third_latch_next;
        timer_clk_next = first_sync[gpio_port_pkg::PIN_TIMER_CLK];
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            first_latch_reg <= gpio_port_pkg::RST_LATCH;
            first_dir_reg <= gpio_port_pkg::RST_DIR;
            third_latch_reg <= gpio_port_pkg::RST_LATCH;
            third_dir_reg <= gpio_port_pkg::RST_DIR;
            fifth_dir_reg <= gpio_port_pkg::RST_FIFTH_DIR;
            mode_reg <= 1'b0;
            ibf_reg <= 1'b0;
            obf_reg <= 1'b0;
            input_buffer_overflow_reg <= 1'b0;
            analog_sel_reg <= gpio_port_pkg::RST_ANALOG_SEL;
            osc_sel_reg <= gpio_port_pkg::RST_OSC_SEL;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            rdata_reg <= '0;
            first_out_reg <= '0;
            first_oe_reg <= '0;
            third_out_reg <= '0;
            third_oe_reg <= '0;
            timer_clk_reg <= 1'b0;
        end else begin
            first_latch_reg <= first_latch_next;
            first_dir_reg <= first_dir_next;
            third_latch_reg <= third_latch_next;
            third_dir_reg <= third_dir_next;
            fifth_dir_reg <= fifth_dir_next;
            mode_reg <= mode_next;
            ibf_reg <= ibf_next;
            obf_reg <= obf_next;
            input_buffer_overflow_reg <= input_buffer_overflow_next;
            analog_sel_reg <= analog_sel_next;
            osc_sel_reg <= osc_sel_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg <= rdata_next;
            first_out_reg <= first_out_next;
            first_oe_reg <= first_oe_next;
            third_out_reg <= third_out_next;
            third_oe_reg <= third_oe_next;
            timer_clk_reg <= timer_clk_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero wait states, response always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign first_port_out = first_out_reg;
    assign first_port_oe = first_oe_reg;
    assign third_port_out = third_out_reg;
    assign third_port_oe = third_oe_reg;
    assign fifth_port_dir = fifth_dir_reg;
    assign slave_port_mode_select = mode_reg;
    assign timer_zero_clock_input = timer_clk_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_write_first(logic [7:0] ofs);
        addr_phase && hwrite && haddr[7:0] == ofs;
    endsequence

    sequence s_read_first(logic [7:0] ofs);
        addr_phase && !hwrite && haddr[7:0] == ofs;
    endsequence

    a_dir_one_off: assert property (first_dir_reg[0] |-> !first_port_oe[0])
        else $error("input pin still driven");
    a_dir_zero_drive: assert property (
        !first_dir_reg[1] |-> first_port_oe[1] && first_port_out[1] == first_latch_reg[1])
        else $error("output pin not driven from latch");
    a_pin_write_latch: assert property (
        s_write_first(gpio_port_pkg::OFS_FIRST_PIN_VALUE) ##1 1'b1 |=> first_latch_reg == $past(hwdata[7:0]))
        else $error("pin value write missed the latch");
    a_latch_write_same: assert property (
        s_write_first(gpio_port_pkg::OFS_FIRST_LATCH) ##1 1'b1 |=> first_latch_reg == $past(hwdata[7:0]))
        else $error("latch write missed the latch");
    a_latch_readback: assert property (
        s_read_first(gpio_port_pkg::OFS_FIRST_LATCH) && !wr_pend_reg && !osc_sel_reg
        |=> hrdata[7:0] == first_latch_reg)
        else $error("latch read not the latched value");
    a_pin_read_back: assert property (
        s_read_first(gpio_port_pkg::OFS_FIRST_PIN_VALUE)
        |=> hrdata[7:0] == ($past(first_sync) & ~analog_mask($past(analog_sel_next))
        & ~osc_mask($past(osc_sel_next))))
        else $error("pin read not the pin level");
    a_timer_clock: assert property (
        ##1 timer_zero_clock_input == $past(first_sync[gpio_port_pkg::PIN_TIMER_CLK]))
        else $error("timer clock not following pin four");
    a_osc_pins_quiet: assert property (osc_sel_reg |-> first_port_oe[7:6] == 2'b00)
        else $error("oscillator pins driven");
    a_analog_read_zero: assert property (
        s_read_first(gpio_port_pkg::OFS_FIRST_PIN_VALUE) && analog_sel_reg[0] && !wr_pend_reg
        |=> hrdata[0] == 1'b0)
        else $error("analog pin read not zero");
    a_reset_defaults: assert property (
        $fell(reset) |-> analog_sel_reg == gpio_port_pkg::RST_ANALOG_SEL
        && fifth_dir_reg == gpio_port_pkg::RST_FIFTH_DIR)
        else $error("reset values wrong");
    a_overflow_set: assert property (slave_in_write && ibf_reg |=> input_buffer_overflow_reg ##1 (input_buffer_overflow_reg || $past(ovf_clear)))
        else $error("overflow not set and held");
    a_ibf_set: assert property (slave_in_write |=> ibf_reg)
        else $error("input buffer full not set");
    a_mode_out: assert property (
        s_write_first(gpio_port_pkg::OFS_FIFTH_DIR_STATUS) ##1 1'b1
        |=> slave_port_mode_select == $past(hwdata[gpio_port_pkg::FIFTH_MODE_BIT]))
        else $error("mode bit not steering output");
    a_fifth_bit3_zero: assert property (
        s_read_first(gpio_port_pkg::OFS_FIFTH_DIR_STATUS) |=> hrdata[3] == 1'b0)
        else $error("unused bit reads one");

endmodule

// *** hw/gpio_port_pkg.sv ***
// constants for the general purpose port block: register offsets,
// field positions and values after reset.
// assumes a 32-bit ahb-lite register bus with byte addresses.
package gpio_port_pkg;

    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_FIRST_PIN_VALUE = 8'h00;
    localparam logic [7:0] OFS_FIRST_LATCH = 8'h04;
    localparam logic [7:0] OFS_FIRST_DIR = 8'h08;
    localparam logic [7:0] OFS_THIRD_PIN_VALUE = 8'h0C;
    localparam logic [7:0] OFS_THIRD_LATCH = 8'h10;
    localparam logic [7:0] OFS_THIRD_DIR = 8'h14;
    localparam logic [7:0] OFS_FIFTH_DIR_STATUS = 8'h18;
    localparam logic [7:0] OFS_ANALOG_CTRL_ONE = 8'h1C;
    localparam logic [7:0] OFS_OSC_PIN_SELECT = 8'h20;

    // --------------------------------------------------------------
    // fifth port direction and slave status fields
    // --------------------------------------------------------------
    localparam int FIFTH_IBF_BIT = 7;
    localparam int FIFTH_OBF_BIT = 6;
    localparam int FIFTH_INPUT_BUFFER_OVERFLOW_BIT = 5;
    localparam int FIFTH_MODE_BIT = 4;
    localparam int FIFTH_DIR_W = 3;

    // --------------------------------------------------------------
    // first port pin positions
    // --------------------------------------------------------------
    localparam int PIN_TIMER_CLK = 4;
    localparam int PIN_ANALOG_HI = 5;
    localparam int PIN_OSC_LO = 6;
    localparam int PIN_OSC_HI = 7;
    localparam int ANALOG_SEL_W = 5;

    // --------------------------------------------------------------
    // values after reset
    // --------------------------------------------------------------
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [2:0] RST_FIFTH_DIR = 3'h7;
    localparam logic [4:0] RST_ANALOG_SEL = 5'h1F;
    localparam logic RST_OSC_SEL = 1'b0;
    localparam int SYNC_STAGES = 2;

endpackage

// *** hw/pin_sync.sv ***
// two flip-flop synchroniser for a bus of pin inputs.
// assumes each bit is an independent level; no word coherence.
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // pins and result
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] stable_reg;
    logic [WIDTH-1:0] stable_next;

    // a bus of no bits has nothing to carry
    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync needs at least one bit");
    end

    // ----------------------------------------------------------------
    // synchroniser stages
    // ----------------------------------------------------------------
    // first stage is read only by the second stage
    always_comb begin
        meta_next = pin_in;
        stable_next = meta_reg;
    end

    // reset to zero so no unknown reaches the read paths
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_reg <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign pin_sync_out = stable_reg;

endmodule

// *** sim/pin_partner.sv ***
// partner model: external circuitry sitting on one 8-bit port's pins.
// assumes out/oe come from the port block on clk_sys; bench steers it.
`timescale 1ns/100ps
module pin_partner (
    // clock
    input wire logic clk_sys,
    // block side of the pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // bench control of the far side
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // resolved pin levels
    output logic [7:0] pin_level
);
    logic [7:0] drift_reg = 8'h55;

    // --------------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------------
    // a pin nobody drives floats: never let it repeat a stale level
    always_ff @(posedge clk_sys) begin
        drift_reg <= ~drift_reg;
    end

    // block driver wins where enabled, else far side, else floating
    always_comb begin
        pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & drift_reg);
    end
endmodule

// *** sim/bidir_port_with_direction_latch_test.sv ***
// self-checking bench for the port block over ahb-lite.
// assumes pin_partner on both ports and hready tied to hreadyout.
`timescale 1ns/100ps
module bidir_port_with_direction_latch_test;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [7:0] p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe;
    logic [7:0] ext1 = 8'hff, ext3 = 8'hff;
    logic [3:0] evt = 4'h0;
    logic [2:0] fifth_dir;
    logic mode_sel, tmr_clk;
    int err_count = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h0000_7e2b;

    // --------------------------------------------------------------
    // clock, design and partners
    // --------------------------------------------------------------
    always #12.5 clk_sys = ~clk_sys;

    gpio_port dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .first_port_in(p1_in), .first_port_out(p1_out),
        .first_port_oe(p1_oe), .third_port_in(p3_in), .third_port_out(p3_out), .third_port_oe(p3_oe),
        .slave_in_write(evt[0]), .core_in_read(evt[1]), .core_out_write(evt[2]),
        .slave_out_read(evt[3]), .fifth_port_dir(fifth_dir), .slave_port_mode_select(mode_sel),
        .timer_zero_clock_input(tmr_clk));
    pin_partner first_side (.clk_sys(clk_sys), .pin_out(p1_out), .pin_oe(p1_oe), .ext_val(ext1),
        .ext_en(8'hff), .pin_level(p1_in));
    pin_partner third_side (.clk_sys(clk_sys), .pin_out(p3_out), .pin_oe(p3_oe), .ext_val(ext3),
        .ext_en(8'hff), .pin_level(p3_in));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction

    // pin value read: driven pins show latch, inputs the far side, shared pins 0
    function automatic logic [7:0] exp_pins(input logic [7:0] lat, dir, ext, input logic [4:0] an,
        input logic osc);
        return ((lat & ~dir) | (ext & dir)) & ~{osc, osc, an[4], 1'b0, an[3:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single transfer; waits on hready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0000_00, a};
        hwrite <= wr;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0000_00, wd};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        check(r, {24'h0000_00, exp});
    endtask

    // one-cycle event pulse towards the slave status flags
    task automatic pulse(input int k);
        @(posedge clk_sys);
        evt <= 4'h1 << k;
        @(posedge clk_sys);
        evt <= 4'h0;
    endtask

    task automatic tally_and_finish;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // hang guard, well beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] lat, dir, lat3, dir3, lvl, amask;
        logic [4:0] an;
        logic osc;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        // reset values; synchronisers have settled on all-ones pins
        rd_chk(gpio_port_pkg::OFS_FIRST_DIR, 8'hff);
        rd_chk(gpio_port_pkg::OFS_FIRST_LATCH, 8'h00);
        rd_chk(gpio_port_pkg::OFS_THIRD_DIR, 8'hff);
        rd_chk(gpio_port_pkg::OFS_ANALOG_CTRL_ONE, 8'h1f);
        rd_chk(gpio_port_pkg::OFS_FIRST_PIN_VALUE, 8'hd0);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h07);
        check({24'h0000_00, p1_oe}, 32'h0000_0000);
        check({31'h0, tmr_clk}, 32'h0000_0001);
        $display("test reset values done");

        // random configurations, first one a hand-picked oscillator corner
        for (int i = 0; i < 16; i++) begin
            seed = lfsr_next(seed);
            r = (i == 0) ? 32'h0100_a520 : seed;
            an = r[4:0];
            osc = r[5];
            lat = r[15:8];
            amask = {2'b00, an[4], 1'b0, an[3:0]};
            dir = r[23:16] | amask;
            lat3 = r[31:24];
            dir3 = r[7:0] ^ r[23:16];
            seed = lfsr_next(seed);
            ext1 <= seed[7:0];
            ext3 <= seed[15:8];
            wr_reg(gpio_port_pkg::OFS_ANALOG_CTRL_ONE, {3'b000, an});
            wr_reg(gpio_port_pkg::OFS_OSC_PIN_SELECT, {7'h00, osc});
            wr_reg(r[24] ? gpio_port_pkg::OFS_FIRST_PIN_VALUE : gpio_port_pkg::OFS_FIRST_LATCH, lat);
            wr_reg(gpio_port_pkg::OFS_FIRST_DIR, dir);
            wr_reg(r[25] ? gpio_port_pkg::OFS_THIRD_PIN_VALUE : gpio_port_pkg::OFS_THIRD_LATCH, lat3);
            wr_reg(gpio_port_pkg::OFS_THIRD_DIR, dir3);
            repeat (4) @(posedge clk_sys);
            check({24'h0000_00, p1_oe}, {24'h0000_00, ~dir & ~{osc, osc, 6'h00}});
            check({24'h0000_00, p1_out & p1_oe}, {24'h0000_00, lat & ~dir & ~{osc, osc, 6'h00}});
            check({24'h0000_00, p3_out & p3_oe}, {24'h0000_00, lat3 & ~dir3});
            check({24'h0000_00, p3_oe}, {24'h0000_00, ~dir3});
            lvl = (lat & ~dir) | (seed[7:0] & dir);
            check({31'h0, tmr_clk}, {31'h0, lvl[gpio_port_pkg::PIN_TIMER_CLK]});
            rd_chk(gpio_port_pkg::OFS_FIRST_PIN_VALUE, exp_pins(lat, dir, seed[7:0], an, osc));
            rd_chk(gpio_port_pkg::OFS_FIRST_LATCH, lat & ~{osc, osc, 6'h00});
            rd_chk(gpio_port_pkg::OFS_FIRST_DIR, dir & ~{osc, osc, 6'h00});
            rd_chk(gpio_port_pkg::OFS_THIRD_PIN_VALUE, exp_pins(lat3, dir3, seed[15:8], 5'h00, 1'b0));
            rd_chk(gpio_port_pkg::OFS_THIRD_LATCH, lat3);
            rd_chk(gpio_port_pkg::OFS_THIRD_DIR, dir3);
        end
        $display("test random port setups done");

        // slave status flags, overflow, mode and fifth direction
        pulse(0);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h87);
        pulse(0);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'ha7);
        pulse(1);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h27);
        wr_reg(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'hea);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h22);
        check({29'h0, fifth_dir}, 32'h0000_0002);
        wr_reg(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h17);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h17);
        check({31'h0, mode_sel}, 32'h0000_0001);
        pulse(2);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h57);
        pulse(3);
        wr_reg(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h07);
        rd_chk(gpio_port_pkg::OFS_FIFTH_DIR_STATUS, 8'h07);
        check({31'h0, mode_sel}, 32'h0000_0000);
        $display("test slave status done");

        // mid-run reset brings back the power-on pin setup
        wr_reg(gpio_port_pkg::OFS_FIRST_DIR, 8'h00);
        ext1 <= 8'hff;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd_chk(gpio_port_pkg::OFS_FIRST_DIR, 8'hff);
        rd_chk(gpio_port_pkg::OFS_FIRST_PIN_VALUE, 8'hd0);
        check({24'h0000_00, p1_oe}, 32'h0000_0000);
        $display("test mid-run reset done");

        // unmapped place: writes vanish, reads give zero
        wr_reg(8'h40, 8'h5a);
        rd_chk(8'h40, 8'h00);
        check({31'h0, hresp}, 32'h0000_0000);
        $display("test unmapped access done");
        tally_and_finish();
    end
endmodule
